// ===== design/sarseq_top.sv
// sar conversion sequencer: control of an 8-bit successive-approximation conversion
// Overview of operation
// - conversion takes exactly nine conversion clock edges
// - first cycle rearms busy, prepares trial register
// - eight cycles decide one bit each, top first
// - after edge eight: upper seven valid, busy low
// - after edge nine: bottom bit valid, done
// - outputs keep previous result when request rises
// - straight binary: zero volts all zeros
// - eight parallel bits, highest output is top bit
`default_nettype none
`include "sarseq_consts.svh"

module sarseq_top (
	input  wire logic                 clk_i,
	input  wire logic                 nrst_i,
	input  wire logic                 conv_clk_i,
	input  wire logic                 conv_request_i,
	input  wire logic                 cmp_above_i,
	output logic                      busy_o,
	output logic                      upper_valid_o,
	output logic                      result_valid_o,
	output sarseq_pkg::sarseq_word_t  result_o,
	output sarseq_pkg::sarseq_word_t  dac_code_o,
	output logic                      start_refused_o,
	output logic                      word_valid_o,
	input  wire logic                 word_ready_i,
	output sarseq_pkg::sarseq_word_t  word_data_o
);
	import sarseq_pkg::*;

	// ************************************************************
	// latency notes
	// ************************************************************

	// each pin is seen four system clocks late: three stages and
	// the agreement register; clock, request and comparator share
	// that delay, so their timing relative to each other is kept
	// the conversion clock must stay high and low for two system
	// clocks at least, or the filter swallows the pulse
	// a request left high starts one conversion only; it must be
	// seen low before the next start is taken
	// the result word moves in two steps: upper seven bits at edge
	// eight, bottom bit at edge nine; in between it mixes two words

	// ************************************************************
	// decoding helpers
	// ************************************************************

	// one-hot mask of the bit under trial
	function automatic sarseq_word_t bit_mask(input sarseq_idx_t idx);
		sarseq_word_t m;
		m = '0;
		m[idx] = 1'b1;
		return m;
	endfunction : bit_mask

	// conversion edge count against an edge number
	function automatic logic edge_hit(input sarseq_cnt_t cnt, input sarseq_cnt_t num);
		return (cnt == num);
	endfunction : edge_hit

	// ************************************************************
	// declarations
	// ************************************************************

	// registers and the next-state value
	sarseq_state_t  state_r;
	sarseq_state_t  state_nxt;
	sarseq_cnt_t    edge_cnt_r;
	sarseq_idx_t    bit_idx_r;
	sarseq_word_t   trial_r;
	sarseq_word_t   result_r;
	logic           busy_r;
	logic           upper_valid_r;
	logic           result_valid_r;
	logic           refused_r;
	logic           req_armed_r;
	logic           clk_prev_r;
	logic           push_vld_r;
	sarseq_word_t   push_data_r;

	// pin vectors and decoded wires
	logic [`SARSEQ_PIN_N-1:0] pins;
	logic [`SARSEQ_PIN_N-1:0] pins_s;
	logic           conv_clk_s;
	logic           req_s;
	logic           cmp_s;
	logic           conv_rise;
	logic           in_idle;
	logic           in_decide;
	logic           start_seen;
	logic           start_go;
	logic           start_bad;
	logic           buf_room;
	logic           at_upper;
	logic           at_last;
	sarseq_word_t   cur_mask;
	sarseq_word_t   kept;
	sarseq_word_t   trial_nxt;
	sarseq_cnt_t    edge_cnt_nxt;
	logic           edge_step;
	logic           clash_busy;
	logic           clash_full;
	sarseq_word_t   push_word;

	sarseq_stream_if push_s ();
	sarseq_stream_if pop_s ();

	// ************************************************************
	// pin synchronisers
	// ************************************************************

	assign pins[`SARSEQ_PIN_CLK] = conv_clk_i;
	assign pins[`SARSEQ_PIN_REQ] = conv_request_i;
	assign pins[`SARSEQ_PIN_CMP] = cmp_above_i;

	sarseq_sync #(
		.W       (`SARSEQ_PIN_N)
	) u_sync (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.pin_i   (pins),
		.level_o (pins_s)
	);

	assign conv_clk_s = pins_s[`SARSEQ_PIN_CLK];
	assign req_s      = pins_s[`SARSEQ_PIN_REQ];
	assign cmp_s      = pins_s[`SARSEQ_PIN_CMP];

	// ************************************************************
	// conversion clock edge and request decode
	// ************************************************************

	// request and comparator pass the same delay as the clock, so
	// both are seen as they stood at the conversion clock edge
	assign conv_rise  = conv_clk_s & ~clk_prev_r;
	assign in_idle    = (state_r == SARSEQ_IDLE);
	assign in_decide  = (state_r == SARSEQ_DECIDE);
	// request must have been low since the last start
	assign start_seen = conv_rise & req_s & req_armed_r;
	assign buf_room   = push_s.ready;
	assign start_go   = start_seen & in_idle & buf_room;
	// overlap with a running conversion: request refused
	assign clash_busy = start_seen & ~in_idle;
	// both buffer entries taken: a third word would have no room
	assign clash_full = start_seen & in_idle & ~buf_room;
	assign start_bad  = clash_busy | clash_full;

	// ************************************************************
	// bit trial decode
	// ************************************************************

	assign cur_mask     = bit_mask(bit_idx_r);
	// comparator high: input beyond trial level, keep the bit
	assign kept         = cmp_s ? trial_r : (trial_r & ~cur_mask);
	assign trial_nxt    = kept | (cur_mask >> 1);
	assign edge_cnt_nxt = edge_cnt_r + 4'h1;
	// a conversion edge that decides a bit
	assign edge_step    = in_decide & conv_rise;
	// edge eight: upper seven bits settle, busy ends
	assign at_upper     = edge_step & edge_hit(edge_cnt_nxt, `SARSEQ_UPPER_EDGE);
	// edge nine: bottom bit settles, conversion done
	assign at_last      = edge_step & edge_hit(edge_cnt_nxt, `SARSEQ_LAST_EDGE);
	// word handed to the buffer: upper bits kept, bottom bit fresh
	assign push_word    = {result_r[7:1], kept[0]};

	// ************************************************************
	// state machine
	// ************************************************************

	// idle waits for an armed request with room in the buffer;
	// decide runs from the first edge to the ninth, then returns
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			SARSEQ_IDLE: begin
				if (start_go) begin
					state_nxt = SARSEQ_DECIDE;
				end
			end
			SARSEQ_DECIDE: begin
				if (at_last) begin
					state_nxt = SARSEQ_IDLE;
				end
			end
			default: begin
				state_nxt = SARSEQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_r     <= SARSEQ_IDLE;
			clk_prev_r  <= 1'b0;
			req_armed_r <= 1'b0;
		end else begin
			state_r     <= state_nxt;
			clk_prev_r  <= conv_clk_s;
			req_armed_r <= start_seen ? 1'b0 : (req_armed_r | ~req_s);
		end
	end

	// ************************************************************
	// edge counter and trial register
	// ************************************************************

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			edge_cnt_r <= '0;
			bit_idx_r  <= `SARSEQ_TOP_IDX;
			trial_r    <= `SARSEQ_RES_RST;
		end else if (start_go) begin
			// first cycle: prepare only, no bit decided
			edge_cnt_r <= 4'h1;
			bit_idx_r  <= `SARSEQ_TOP_IDX;
			trial_r    <= `SARSEQ_TRIAL_FIRST;
		end else if (edge_step) begin
			// index wraps to the top bit after edge nine, harmless
			edge_cnt_r <= edge_cnt_nxt;
			bit_idx_r  <= bit_idx_r - 3'h1;
			trial_r    <= at_last ? kept : trial_nxt;
		end
	end

	// ************************************************************
	// busy and result outputs
	// ************************************************************

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			busy_r         <= 1'b0;
			upper_valid_r  <= 1'b0;
			result_valid_r <= 1'b0;
			result_r       <= `SARSEQ_RES_RST;
		end else if (start_go) begin
			// result word left untouched here
			// previous word stays on the outputs until edge eight
			busy_r         <= 1'b1;
			upper_valid_r  <= 1'b0;
			result_valid_r <= 1'b0;
		end else if (at_upper) begin
			busy_r         <= 1'b0;
			upper_valid_r  <= 1'b1;
			result_r[7:1]  <= kept[7:1];
		end else if (at_last) begin
			result_valid_r <= 1'b1;
			result_r[0]    <= kept[0];
		end
	end

	// ************************************************************
	// refusal flag and buffer push
	// ************************************************************

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			refused_r   <= 1'b0;
			push_vld_r  <= 1'b0;
			push_data_r <= `SARSEQ_RES_RST;
		end else begin
			// one-cycle pulse per refused request
			refused_r  <= start_bad;
			push_vld_r <= at_last;
			if (at_last) begin
				push_data_r <= push_word;
			end
		end
	end

	// a start is taken only with a free entry, so the push never stalls;
	// words leave in conversion order, one per finished conversion
	assign push_s.valid = push_vld_r;
	assign push_s.data  = push_data_r;

	sarseq_buf u_buf (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.in_s   (push_s),
		.out_s  (pop_s)
	);

	assign pop_s.ready = word_ready_i;

	// ************************************************************
	// output ports
	// ************************************************************

	// every output is a register; nothing decoded drives a pin
	assign busy_o          = busy_r;
	assign upper_valid_o   = upper_valid_r;
	assign result_valid_o  = result_valid_r;
	assign result_o        = result_r;
	assign dac_code_o      = trial_r;
	assign start_refused_o = refused_r;
	assign word_valid_o    = pop_s.valid;
	assign word_data_o     = pop_s.data;

endmodule : sarseq_top

`default_nettype wire

// ===== design/sarseq_consts.svh
// constants of the sar conversion sequencer
`ifndef SARSEQ_CONSTS_SVH
`define SARSEQ_CONSTS_SVH

// result word width in bits
`define SARSEQ_RES_W        8
// conversion clock edges per conversion
`define SARSEQ_CONV_EDGES   9
// edge counter width
`define SARSEQ_CNT_W        4
// edge number after which the upper seven bits stand
`define SARSEQ_UPPER_EDGE   4'h8
// edge number after which the full word stands
`define SARSEQ_LAST_EDGE    4'h9
// first trial code, top bit set
`define SARSEQ_TRIAL_FIRST  8'h80
// reset value of result and trial registers
`define SARSEQ_RES_RST      8'h00
// top bit index
`define SARSEQ_TOP_IDX      3'h7
// number of input synchroniser stages
`define SARSEQ_SYNC_STAGES  3
// pin bit positions in the synchronised vector
`define SARSEQ_PIN_CLK      0
`define SARSEQ_PIN_REQ      1
`define SARSEQ_PIN_CMP      2
`define SARSEQ_PIN_N        3

`endif

// ===== design/sarseq_pkg.sv
// types of the sar conversion sequencer
`default_nettype none

package sarseq_pkg;

	// sequencer states, one-hot
	typedef enum logic [1:0] {
		SARSEQ_IDLE   = 2'b01,
		SARSEQ_DECIDE = 2'b10
	} sarseq_state_t;

	typedef logic [7:0] sarseq_word_t;
	typedef logic [2:0] sarseq_idx_t;
	typedef logic [3:0] sarseq_cnt_t;

endpackage : sarseq_pkg

`default_nettype wire

// ===== design/sarseq_stream_if.sv
// valid/ready word stream between sequencer parts
`default_nettype none

interface sarseq_stream_if;
	import sarseq_pkg::*;

	logic         valid;
	logic         ready;
	sarseq_word_t data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);

endinterface : sarseq_stream_if

`default_nettype wire

// ===== design/sarseq_sync.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none
`include "sarseq_consts.svh"

module sarseq_sync #(
	parameter int W = `SARSEQ_PIN_N
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] level_r;
	logic [W-1:0] agree;

	assign agree   = ~(s2_r ^ s3_r);
	assign level_o = level_r;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_r    <= '0;
			s2_r    <= '0;
			s3_r    <= '0;
			level_r <= '0;
		end else begin
			s1_r    <= pin_i;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			level_r <= (agree & s3_r) | (~agree & level_r);
		end
	end

endmodule : sarseq_sync

`default_nettype wire

// ===== design/sarseq_buf.sv
// two-entry result buffer, registered output
`default_nettype none

module sarseq_buf (
	input  wire logic     clk_i,
	input  wire logic     nrst_i,
	sarseq_stream_if.snk  in_s,
	sarseq_stream_if.src  out_s
);
	import sarseq_pkg::*;

	sarseq_word_t main_r;
	sarseq_word_t skid_r;
	logic         main_vld_r;
	logic         skid_vld_r;
	logic         in_fire;
	logic         main_free;

	// ready drops only when both entries hold a word
	assign in_s.ready  = ~skid_vld_r;
	assign in_fire     = in_s.valid & ~skid_vld_r;
	assign main_free   = ~main_vld_r | out_s.ready;
	assign out_s.valid = main_vld_r;
	assign out_s.data  = main_r;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			main_r     <= '0;
			skid_r     <= '0;
			main_vld_r <= 1'b0;
			skid_vld_r <= 1'b0;
		end else if (main_free) begin
			if (skid_vld_r) begin
				main_r     <= skid_r;
				main_vld_r <= 1'b1;
				skid_vld_r <= 1'b0;
			end else begin
				main_vld_r <= in_fire;
				if (in_fire) begin
					main_r <= in_s.data;
				end
			end
		end else if (in_fire) begin
			skid_r     <= in_s.data;
			skid_vld_r <= 1'b1;
		end
	end

endmodule : sarseq_buf

`default_nettype wire

// ===== bench/sarseq_sva.sv
// assertion checker of the sar conversion sequencer
`default_nettype none

module sarseq_sva (
	input wire logic                     clk_i,
	input wire logic                     nrst_i,
	input wire logic                     conv_clk_i,
	input wire logic                     conv_request_i,
	input wire logic                     cmp_above_i,
	input wire logic                     busy_o,
	input wire logic                     upper_valid_o,
	input wire logic                     result_valid_o,
	input wire sarseq_pkg::sarseq_word_t result_o,
	input wire sarseq_pkg::sarseq_word_t dac_code_o,
	input wire logic                     start_refused_o,
	input wire logic                     word_valid_o,
	input wire logic                     word_ready_i,
	input wire sarseq_pkg::sarseq_word_t word_data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import sarseq_pkg::*;
	logic       cclk_r;
	logic [3:0] edges_r;
	// conversion clock rises seen while busy
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cclk_r  <= 1'b0;
			edges_r <= 4'h0;
		end else begin
			cclk_r  <= conv_clk_i;
			if (!busy_o)
				edges_r <= 4'h0;
			else if (conv_clk_i && !cclk_r)
				edges_r <= edges_r + 4'h1;
		end
	end
	default clocking dc @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	a_start_trial: assert property (
		$rose(busy_o) |-> dac_code_o == 8'h80 && !upper_valid_o && !result_valid_o)
		else $error("trial code or flags wrong at start");
	a_conv_edges: assert property (
		$fell(busy_o) |-> edges_r == 4'h7) else $error("busy length wrong");
	a_busy_upper: assert property (
		$fell(busy_o) |-> upper_valid_o && !result_valid_o) else $error("upper bits late");
	a_upper_wait: assert property (
		$rose(upper_valid_o) |-> !result_valid_o [*5]) else $error("bottom bit early");
	a_low_bit_held: assert property (
		upper_valid_o && !result_valid_o |-> $stable(result_o[0])) else $error("bottom bit moved");
	a_full_flags: assert property (
		result_valid_o |-> upper_valid_o && !busy_o) else $error("flag mix wrong");
	a_result_held: assert property (
		busy_o |-> $stable(result_o)) else $error("result changed while busy");
	a_refuse_pulse: assert property (
		start_refused_o |=> !start_refused_o) else $error("refusal not one cycle");
	a_word_hold: assert property (
		word_valid_o && !word_ready_i |=> word_valid_o && $stable(word_data_o))
		else $error("word dropped under stall");
endmodule : sarseq_sva

bind sarseq_top sarseq_sva u_sva (
	.clk_i           (clk_i),
	.nrst_i          (nrst_i),
	.conv_clk_i      (conv_clk_i),
	.conv_request_i  (conv_request_i),
	.cmp_above_i     (cmp_above_i),
	.busy_o          (busy_o),
	.upper_valid_o   (upper_valid_o),
	.result_valid_o  (result_valid_o),
	.result_o        (result_o),
	.dac_code_o      (dac_code_o),
	.start_refused_o (start_refused_o),
	.word_valid_o    (word_valid_o),
	.word_ready_i    (word_ready_i),
	.word_data_o     (word_data_o)
);

`default_nettype wire

// ===== bench/sarseq_ctl_model.sv
// controller model: conversion clock, start request, comparator
`default_nettype none

module sarseq_ctl_model (
	input  wire logic                     clk_i,
	input  wire sarseq_pkg::sarseq_word_t dac_code_i,
	output logic                          conv_clk_o,
	output logic                          conv_request_o,
	output logic                          cmp_above_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import sarseq_pkg::*;
	sarseq_word_t level = 8'h00;
	int           half  = 4;
	// input at or beyond trial level keeps the bit
	assign cmp_above_o = (dac_code_i <= level);
	initial begin
		conv_clk_o     = 1'b0;
		conv_request_o = 1'b0;
	end
	// clock stands low outside frames
	task automatic pulses(input int n);
		repeat (n) begin
			conv_clk_o <= 1'b1;
			repeat (half) @(posedge clk_i);
			conv_clk_o <= 1'b0;
			repeat (half) @(posedge clk_i);
		end
	endtask : pulses
	task automatic start(input sarseq_word_t code);
		level = code;
		conv_request_o <= 1'b1;
		repeat (half) @(posedge clk_i);
		pulses(1);
		conv_request_o <= 1'b0;
	endtask : start
endmodule : sarseq_ctl_model

`default_nettype wire

// ===== bench/sarseq_tb_top.sv
// testbench of the sar conversion sequencer
`default_nettype none

module sarseq_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sarseq_pkg::*;
	logic         clk_i = 1'b0;
	logic         nrst_i = 1'b0;
	logic         word_ready_i = 1'b0;
	logic         conv_clk, request, cmp, busy, upper, rvalid, refused, wvalid;
	sarseq_word_t result, dac, wdata;
	int           miscompares = 0;
	int           compares = 0;
	int           refusals = 0;
	int           r0;

	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) if (refused === 1'b1) refusals++;

	sarseq_ctl_model u_ctl (.clk_i(clk_i), .dac_code_i(dac), .conv_clk_o(conv_clk),
		.conv_request_o(request), .cmp_above_o(cmp));
	sarseq_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .conv_clk_i(conv_clk),
		.conv_request_i(request), .cmp_above_i(cmp), .busy_o(busy), .upper_valid_o(upper),
		.result_valid_o(rvalid), .result_o(result), .dac_code_o(dac),
		.start_refused_o(refused), .word_valid_o(wvalid), .word_ready_i(word_ready_i),
		.word_data_o(wdata));

	// ****************
	// shared tasks
	// ****************
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : end_of_test
	task automatic take_word(input sarseq_word_t exp);
		int i;
		// let an edge that may have reloaded the word settle
		@(posedge clk_i);
		for (i = 0; i < 60 && wvalid !== 1'b1; i++) @(posedge clk_i);
		if (i == 60) begin
			miscompares++;
			end_of_test();
		end
		check("word_data_o", wdata, exp);
		word_ready_i <= 1'b1;
		@(posedge clk_i);
		word_ready_i <= 1'b0;
	endtask : take_word
	task automatic convert(input sarseq_word_t code);
		u_ctl.start(code);
		u_ctl.pulses(8);
	endtask : convert

	// ****************
	// scenarios
	// ****************
	task automatic sc_codes;
		sarseq_word_t codes[6] = '{8'h00, 8'hff, 8'h01, 8'h80, 8'h7f, 8'ha5};
		foreach (codes[k]) begin
			convert(codes[k]);
			check("result_o", result, codes[k]);
			check("result_valid_o", rvalid, 8'h01);
			check("busy_o", busy, 8'h00);
			take_word(codes[k]);
		end
	endtask : sc_codes
	task automatic sc_phases;
		convert(8'hff);
		take_word(8'hff);
		u_ctl.half = 7;
		u_ctl.start(8'h00);
		u_ctl.pulses(6);
		check("result_o", result, 8'hff);
		check("busy_o", busy, 8'h01);
		check("upper_valid_o", upper, 8'h00);
		u_ctl.pulses(1);
		check("result_o", result, 8'h01);
		check("busy_o", busy, 8'h00);
		check("upper_valid_o", upper, 8'h01);
		check("result_valid_o", rvalid, 8'h00);
		u_ctl.pulses(1);
		check("result_o", result, 8'h00);
		check("result_valid_o", rvalid, 8'h01);
		take_word(8'h00);
		u_ctl.half = 4;
	endtask : sc_phases
	task automatic sc_refuse;
		r0 = refusals;
		u_ctl.start(8'h3c);
		u_ctl.pulses(2);
		u_ctl.start(8'h3c);
		u_ctl.pulses(5);
		check("start_refused_o", 8'(refusals - r0), 8'h01);
		check("result_o", result, 8'h3c);
		take_word(8'h3c);
		convert(8'h11);
		convert(8'h22);
		convert(8'h33);
		check("start_refused_o", 8'(refusals - r0), 8'h02);
		check("result_o", result, 8'h22);
		take_word(8'h11);
		take_word(8'h22);
		@(posedge clk_i);
		check("word_valid_o", wvalid, 8'h00);
	endtask : sc_refuse

	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		end_of_test();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		sc_codes();
		sc_phases();
		sc_refuse();
		end_of_test();
	end
endmodule : sarseq_tb_top

`default_nettype wire
